// >>> bench/dma_control_monitor.sv
// Checker for the DMA control block, watching only its ports.
// Assumes lane 0 carries register data and pready answers in the access phase.
`timescale 1ns/1ps
module dma_control_monitor (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   input wire logic [1:0] count_load, // Count load pulses
   input wire logic [1:0] byte_done, // Byte moved pulses
   input wire logic [1:0] xfer_req, // Transfer requests
   input wire logic [15:0] ch0_byte_count, // Channel 0 remaining
   input wire logic [1:0] ch0_dest_mode, // Channel 0 destination
   input wire logic [1:0] ch0_source_mode, // Channel 0 source
   input wire logic [1:0] ch1_direction_mode, // Channel 1 mode
   input wire logic [1:0] memory_wait_count, // Memory waits
   input wire logic [2:0] io_wait_states, // I/O waits
   input wire logic ch0_burst, // Channel 0 holds bus
   input wire logic [1:0] dma_irq // Termination interrupts
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Register writes that really land (lane 0 enabled)
   wire wr = psel && penable && pwrite && pstrb[0];
   wire wr_st = wr && paddr == {2'b00, dma_ctrl_pkg::status_addr};
   wire wr_md = wr && paddr == {2'b00, dma_ctrl_pkg::mode_addr};
   wire wr_wt = wr && paddr == {2'b00, dma_ctrl_pkg::wait_addr};
   wire mem0 = ch0_dest_mode != 2'b11 && ch0_source_mode != 2'b11;
   // Code 0 adds nothing, the others skip one wait
   function automatic logic [2:0] io_map(input logic [1:0] c);
      return (c == 2'b00) ? 3'h0 : {1'b0, c} + 3'h1;
   endfunction
   a_mem_wait: assert property (wr_wt |=> memory_wait_count == $past(pwdata[7:6]))
      else $error("memory wait field not loaded");
   a_io_wait: assert property (wr_wt |=> io_wait_states == io_map($past(pwdata[5:4])))
      else $error("io wait decode wrong");
   a_ch1_mode: assert property (wr_wt |=> ch1_direction_mode == $past(pwdata[1:0]))
      else $error("channel 1 mode not loaded");
   a_dest_mode: assert property (wr_md |=> ch0_dest_mode == $past(pwdata[5:4]))
      else $error("destination mode not loaded");
   a_src_mode: assert property (wr_md |=> ch0_source_mode == $past(pwdata[3:2]))
      else $error("source mode not loaded");
   a_burst_io: assert property (ch0_burst |-> mem0)
      else $error("burst with an io side");
   a_count_step: assert property (byte_done[0] && !count_load[0] && ch0_byte_count != 16'h0000
      |=> ch0_byte_count == $past(ch0_byte_count) - 16'h0001)
      else $error("byte count did not step");
   a_req_count: assert property (xfer_req[0] |-> ch0_byte_count != 16'h0000)
      else $error("request with zero count");
   a_irq_hold: assert property (dma_irq[0] && !wr_st |=> dma_irq[0])
      else $error("interrupt dropped by itself");
   a_steal_gap: assert property (byte_done[0] && !ch0_burst && mem0 |=> !xfer_req[0])
      else $error("no cpu cycle after stolen byte");
   a_reset_vals: assert property ($rose(presetn) |->
      dma_irq == 2'b00 && memory_wait_count == 2'b11 && io_wait_states == 3'h4)
      else $error("reset values wrong");
endmodule
bind dma_control dma_control_monitor i_dma_control_monitor (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .count_load(count_load),
   .byte_done(byte_done),
   .xfer_req(xfer_req),
   .ch0_byte_count(ch0_byte_count),
   .ch0_dest_mode(ch0_dest_mode),
   .ch0_source_mode(ch0_source_mode),
   .ch1_direction_mode(ch1_direction_mode),
   .memory_wait_count(memory_wait_count),
   .io_wait_states(io_wait_states),
   .ch0_burst(ch0_burst),
   .dma_irq(dma_irq)
);

// >>> bench/dma_control_test.sv
// Self-checking bench for the DMA control block with a bus unit stand-in.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module dma_control_test;
   localparam logic [9:0] st = dma_ctrl_pkg::status_addr;
   localparam logic [9:0] md = dma_ctrl_pkg::mode_addr;
   localparam logic [9:0] wt = dma_ctrl_pkg::wait_addr;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi = 0, slow = 0;
   logic dreq0 = 0, dreq1 = 0, pready, pslverr, ch0_burst, err_q;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF;
   logic [1:0] count_load = 2'b00, byte_done, xfer_req, ch0_dest_mode, ch0_source_mode;
   logic [1:0] ch1_direction_mode, memory_wait_count, dma_irq;
   logic [15:0] count_value = 16'h0, ch0_byte_count, ch1_byte_count;
   logic [2:0] io_wait_states;
   int fails = 0, checks = 0, cyc = 0;
   dma_control i_dma_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nmi(nmi), .dreq0(dreq0), .dreq1(dreq1),
      .count_load(count_load), .count_value(count_value), .byte_done(byte_done),
      .xfer_req(xfer_req), .ch0_byte_count(ch0_byte_count), .ch1_byte_count(ch1_byte_count),
      .ch0_dest_mode(ch0_dest_mode), .ch0_source_mode(ch0_source_mode),
      .ch1_direction_mode(ch1_direction_mode), .memory_wait_count(memory_wait_count),
      .io_wait_states(io_wait_states), .ch0_burst(ch0_burst), .dma_irq(dma_irq));
   dma_far_model i_dma_far_model (.pclk(pclk), .presetn(presetn), .slow(slow),
      .xfer_req(xfer_req), .byte_done(byte_done));
   // Clock and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, then an idle cycle so strobes never flip in one step
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
      output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, a};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, r);
      chk(r, {24'h0, e});
   endtask
   task automatic load(input int ch, input logic [15:0] v);
      count_load[ch] <= 1'b1;
      count_value <= v;
      @(posedge pclk);
      count_load <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic wait_cnt(input int ch);
      for (int i = 0; i < 80 && (ch ? ch1_byte_count : ch0_byte_count) !== 16'h0; i++)
         @(posedge pclk);
   endtask
   task automatic t_reset();
      logic [31:0] r;
      rd(st, 8'h30);
      rd(md, 8'h00);
      rd(wt, 8'hF0);
      apb(1'b0, 10'h0D0, 8'h00, r);
      chk(r, 32'h0);
      chk(err_q, 1'b1);
   endtask
   task automatic t_wait();
      for (int c = 0; c < 4; c++) begin
         wr(wt, {4{c[1:0]}});
         chk(memory_wait_count, c);
         chk(io_wait_states, c == 0 ? 0 : c + 1);
         chk(ch1_direction_mode, c);
         rd(wt, {4{c[1:0]}});
      end
   endtask
   task automatic t_modes();
      for (int i = 0; i < 16; i++) begin
         if (i[3] && i[1]) continue;
         wr(md, {2'b00, i[3:0], 2'b10});
         chk(ch0_dest_mode, i[3:2]);
         chk(ch0_source_mode, i[1:0]);
         chk(ch0_burst, i[3:2] != 3 && i[1:0] != 3);
         rd(md, {2'b00, i[3:0], 2'b10});
      end
      wr(md, 8'h00);
   endtask
   task automatic t_enable();
      wr(st, 8'hF0);
      rd(st, 8'h30);
      wr(st, 8'h40);
      rd(st, 8'h71);
      nmi <= 1'b1;
      @(posedge pclk);
      nmi <= 1'b0;
      @(posedge pclk);
      rd(st, 8'h70);
      wr(st, 8'h31);
      rd(st, 8'h70);
      slow <= 1'b1;
      load(0, 16'h0005);
      repeat (4) @(posedge pclk);
      chk(ch0_byte_count, 16'h0005);
      wr(st, 8'h60);
      wait_cnt(0);
      chk(ch0_byte_count, 16'h0000);
      rd(st, 8'h31);
      slow <= 1'b0;
   endtask
   task automatic t_irq();
      wr(st, 8'h34);
      chk(dma_irq, 2'b01);
      repeat (3) @(posedge pclk);
      chk(dma_irq, 2'b01);
      wr(st, 8'h38);
      chk(dma_irq, 2'b10);
      wr(st, 8'h30);
      chk(dma_irq, 2'b00);
   endtask
   task automatic t_sense();
      // level sense for an I/O source, edge for an I/O destination
      wr(wt, 8'hF2);
      load(1, 16'h0002);
      wr(st, 8'h90);
      repeat (4) @(posedge pclk);
      chk(ch1_byte_count, 16'h0002);
      dreq1 <= 1'b1;
      wait_cnt(1);
      chk(ch1_byte_count, 16'h0000);
      rd(st, 8'h31);
      wr(wt, 8'hF4);
      load(1, 16'h0002);
      wr(st, 8'h90);
      // A request already high is no edge, so nothing moves yet
      repeat (6) @(posedge pclk);
      chk(ch1_byte_count, 16'h0002);
      dreq1 <= 1'b0;
      @(posedge pclk);
      dreq1 <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(ch1_byte_count, 16'h0001);
      dreq1 <= 1'b0;
      @(posedge pclk);
      dreq1 <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(ch1_byte_count, 16'h0000);
      dreq1 <= 1'b0;
      rd(st, 8'h31);
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_wait();
      t_modes();
      t_enable();
      t_irq();
      t_sense();
      report_and_stop();
   end
endmodule

// >>> bench/dma_far_model.sv
// Bus unit stand-in that grants the cycles a channel asks for.
// Assumes xfer_req is a level that may drop in the cycle after a byte.
`timescale 1ns/1ps
module dma_far_model (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic slow, // Grant every other cycle
   input wire logic [1:0] xfer_req, // Channel requests
   output logic [1:0] byte_done // Byte moved
);
   logic grant_q;
   // Slow mode stalls every other cycle to stretch transfers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_q <= 1'b0;
      end else begin
         grant_q <= slow ? !grant_q : 1'b1;
      end
   end
   // Never grants a channel that is not asking
   assign byte_done = xfer_req & {2{grant_q}};
endmodule

// >>> rtl/dma_chan_ctl.sv
// One DMA channel's request sensing, byte counter and pacing.
// Assumes a synchronous request input and a one-cycle byte_done from the bus unit.
`timescale 1ns/1ps
module dma_chan_ctl #(
   parameter int cw = 16
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic active, // Enable and master enable both set
   input wire logic edge_sense, // 1 edge, 0 level request
   input wire logic use_request, // Paced by request input
   input wire logic burst, // Memory burst pacing
   input wire logic dreq, // Peripheral request
   input wire logic count_load, // Software loads count
   input wire logic [cw-1:0] count_value, // Count to load
   input wire logic byte_done, // One byte moved
   output logic xfer_req, // Wants a bus cycle
   output logic terminate, // Count hit zero, pulse
   output logic [cw-1:0] count_q // Remaining bytes
);
   logic dreq_q;
   logic edge_pend_q;
   logic steal_q;

   // Previous request for edge sense
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dreq_q <= 1'b0;
      end else begin
         dreq_q <= dreq;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_pend_q <= 1'b0;
      end else if (dreq && !dreq_q) begin
         edge_pend_q <= 1'b1;
      end else if (byte_done) begin
         edge_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         steal_q <= 1'b0;
      end else begin
         steal_q <= byte_done && !burst;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= '0;
      end else if (count_load) begin
         count_q <= count_value;
      end else if (byte_done && count_q != '0) begin
         count_q <= count_q - cw'(1);
      end
   end

   assign terminate = byte_done && (count_q == cw'(1));

   always_comb begin
      if (!active || count_q == '0) begin
         xfer_req = 1'b0;
      end else if (use_request) begin
         xfer_req = edge_sense ? edge_pend_q : dreq;
      end else begin
         xfer_req = !steal_q;
      end
   end
endmodule

// >>> rtl/dma_control.sv
// DMA control, status, channel 0 mode and wait/sense registers on APB.
// Assumes a bus unit that reports byte_done per channel and an NMI pulse.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module dma_control (
   input wire logic pclk, // System clock, 100 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic nmi, // Non-maskable interrupt pulse
   input wire logic dreq0, // Channel 0 request
   input wire logic dreq1, // Channel 1 request
   input wire logic [1:0] count_load, // Load byte count, per channel
   input wire logic [15:0] count_value, // Byte count to load
   input wire logic [1:0] byte_done, // One byte moved, per channel
   output logic [1:0] xfer_req, // Channel wants a transfer
   output logic [15:0] ch0_byte_count, // Channel 0 remaining
   output logic [15:0] ch1_byte_count, // Channel 1 remaining
   output logic [1:0] ch0_dest_mode, // Channel 0 destination
   output logic [1:0] ch0_source_mode, // Channel 0 source
   output logic [1:0] ch1_direction_mode, // Channel 1 mode
   output logic [1:0] memory_wait_count, // Memory waits 0..3
   output logic [2:0] io_wait_states, // I/O waits 0,2,3,4
   output logic ch0_burst, // Channel 0 holds bus
   output logic [1:0] dma_irq // Termination interrupt, per channel
);
   logic ch1_enable_q;
   logic ch0_enable_q;
   logic ch1_irq_enable_q;
   logic ch0_irq_enable_q;
   logic dma_master_enable_q;
   logic [7:0] mode_q;
   logic [7:0] wait_q;
   logic wr;
   logic rd;
   logic hit_status;
   logic hit_mode;
   logic hit_wait;
   logic mapped;
   logic [1:0] term;
   logic ch0_io;
   logic [7:0] status_rd;

   // No wait states; every access answers in its first access cycle
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign rd = psel && penable && !pwrite;
   // Full byte address compare; the package constants are already index times four
   assign hit_status = paddr == {2'b00, dma_ctrl_pkg::status_addr};
   assign hit_mode = paddr == {2'b00, dma_ctrl_pkg::mode_addr};
   assign hit_wait = paddr == {2'b00, dma_ctrl_pkg::wait_addr};
   assign mapped = hit_status || hit_mode || hit_wait;
   assign pslverr = psel && penable && !mapped;

   // guarded enable writes, writes and restart, clear at end
   // Hardware termination wins over a software set in the same cycle? No:
   // a fresh write of 1 restarts, so software set beats the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch1_enable_q <= 1'b0;
         ch0_enable_q <= 1'b0;
      end else begin
         if (wr && hit_status && !pwdata[dma_ctrl_pkg::ch1_guard_bit]) begin
            ch1_enable_q <= pwdata[dma_ctrl_pkg::ch1_en_bit];
         end else if (term[1]) begin
            ch1_enable_q <= 1'b0;
         end
         if (wr && hit_status && !pwdata[dma_ctrl_pkg::ch0_guard_bit]) begin
            ch0_enable_q <= pwdata[dma_ctrl_pkg::ch0_en_bit];
         end else if (term[0]) begin
            ch0_enable_q <= 1'b0;
         end
      end
   end

   // Interrupt enables, plain read/write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch1_irq_enable_q <= 1'b0;
         ch0_irq_enable_q <= 1'b0;
      end else if (wr && hit_status) begin
         ch1_irq_enable_q <= pwdata[dma_ctrl_pkg::ch1_ie_bit];
         ch0_irq_enable_q <= pwdata[dma_ctrl_pkg::ch0_ie_bit];
      end
   end

   // master enable only set through enable writes
   // Setting by a guarded enable write wins over an NMI in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_master_enable_q <= 1'b0;
      end else if (wr && hit_status &&
                   ((!pwdata[dma_ctrl_pkg::ch1_guard_bit] && pwdata[dma_ctrl_pkg::ch1_en_bit]) ||
                    (!pwdata[dma_ctrl_pkg::ch0_guard_bit] && pwdata[dma_ctrl_pkg::ch0_en_bit]))) begin
         dma_master_enable_q <= 1'b1;
      end else if (nmi) begin
         dma_master_enable_q <= 1'b0;
      end
   end

   // channel 0 mode register, pacing reset 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= dma_ctrl_pkg::mode_reset;
      end else if (wr && hit_mode) begin
         mode_q <= pwdata[7:0] & 8'h3E;
      end
   end

   // wait fields reset to 11, sense, channel 1 mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= dma_ctrl_pkg::wait_reset;
      end else if (wr && hit_wait) begin
         wait_q <= pwdata[7:0];
      end
   end

   // Field decode
   assign ch0_dest_mode = mode_q[dma_ctrl_pkg::dest_lsb +: 2];
   assign ch0_source_mode = mode_q[dma_ctrl_pkg::src_lsb +: 2];
   assign ch1_direction_mode = wait_q[dma_ctrl_pkg::ch1_dir_lsb +: 2];
   assign memory_wait_count = wait_q[dma_ctrl_pkg::mem_wait_lsb +: 2];
   // any I/O side uses the request line and ignores pacing bit
   assign ch0_io = (ch0_dest_mode == 2'(dma_ctrl_pkg::step_io)) ||
                   (ch0_source_mode == 2'(dma_ctrl_pkg::step_io));
   assign ch0_burst = mode_q[dma_ctrl_pkg::pacing_bit] && !ch0_io;

   always_comb begin
      case (wait_q[dma_ctrl_pkg::io_wait_lsb +: 2])
         2'b00: io_wait_states = dma_ctrl_pkg::io_wait_0;
         2'b01: io_wait_states = dma_ctrl_pkg::io_wait_1;
         2'b10: io_wait_states = dma_ctrl_pkg::io_wait_2;
         default: io_wait_states = dma_ctrl_pkg::io_wait_3;
      endcase
   end

   // channel 0 gated by both enables
   dma_chan_ctl #(.cw(dma_ctrl_pkg::count_width)) u_ch0 (
      .pclk(pclk),
      .presetn(presetn),
      .active(ch0_enable_q && dma_master_enable_q),
      .edge_sense(wait_q[dma_ctrl_pkg::sense_ch0_bit]),
      .use_request(ch0_io),
      .burst(ch0_burst),
      .dreq(dreq0),
      .count_load(count_load[0]),
      .count_value(count_value),
      .byte_done(byte_done[0]),
      .xfer_req(xfer_req[0]),
      .terminate(term[0]),
      .count_q(ch0_byte_count)
   );

   // channel 1 gated by both enables; always I/O paced
   dma_chan_ctl #(.cw(dma_ctrl_pkg::count_width)) u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .active(ch1_enable_q && dma_master_enable_q),
      .edge_sense(wait_q[dma_ctrl_pkg::sense_ch1_bit]),
      .use_request(1'b1),
      .burst(1'b0),
      .dreq(dreq1),
      .count_load(count_load[1]),
      .count_value(count_value),
      .byte_done(byte_done[1]),
      .xfer_req(xfer_req[1]),
      .terminate(term[1]),
      .count_q(ch1_byte_count)
   );

   // level interrupt while disabled and enabled for irq
   assign dma_irq[1] = !ch1_enable_q && ch1_irq_enable_q;
   assign dma_irq[0] = !ch0_enable_q && ch0_irq_enable_q;

   assign status_rd = {ch1_enable_q, ch0_enable_q, 2'b00, ch1_irq_enable_q,
                       ch0_irq_enable_q, 1'b0, dma_master_enable_q}
                      | dma_ctrl_pkg::guard_read;

   // Registered read data; unmapped reads return zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_status) begin
            prdata <= {24'h000000, status_rd};
         end else if (hit_mode) begin
            prdata <= {24'h000000, mode_q};
         end else if (hit_wait) begin
            prdata <= {24'h000000, wait_q};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
endmodule

// >>> rtl/dma_ctrl_pkg.sv
// Package for the two-channel DMA control, status and mode block.
// Assumes an APB slave with 32-bit data; registers occupy one word each.
// Function
// - Channel transfers only while its enable and master enable are both set.
// - Byte count reaching zero at termination clears that channel enable.
// - Interrupt request while channel enable is 0 and interrupt enable is 1.
// - Enable bit written only when its write guard is written 0.
// - Both write guard bits always read as 1.
// - Writing enable 1 sets master enable; writing 0 stops, restartable.
// - Non-maskable interrupt clears master enable.
// - Master enable ignores direct writes; rewrite channel enables to resume.
// - Reset clears channel enables, interrupt enables and master enable.
// - Channel 0 destination mode: memory +1, -1, fixed, or I/O fixed.
// - Channel 0 source mode uses the same four-way encoding.
// - Burst pacing holds the bus until channel 0 count is zero.
// - Cycle-steal pacing gives CPU one cycle after each byte.
// - I/O channel 0 paced by request input; pacing bit resets to 0.
// - Memory wait field adds 0 to 3 waits; resets to 3.
// - I/O wait field adds 0, 2, 3 or 4 waits; resets to code 3, giving 4 waits.
// - Request sense bits select edge (1) or level (0); reset 0.
// - Channel 1 mode selects direction and memory step; I/O fixed.
// - Each transferred byte decrements the 16-bit byte count.
package dma_ctrl_pkg;
   // Register byte addresses (offsets 0x30..0x32 kept as indices)
   localparam logic [7:0] status_idx = 8'h30;
   localparam logic [7:0] mode_idx = 8'h31;
   localparam logic [7:0] wait_idx = 8'h32;
   localparam logic [9:0] status_addr = {status_idx, 2'b00};
   localparam logic [9:0] mode_addr = {mode_idx, 2'b00};
   localparam logic [9:0] wait_addr = {wait_idx, 2'b00};
   // Status/control fields
   localparam int ch1_en_bit = 7;
   localparam int ch0_en_bit = 6;
   localparam int ch1_guard_bit = 5;
   localparam int ch0_guard_bit = 4;
   localparam int ch1_ie_bit = 3;
   localparam int ch0_ie_bit = 2;
   localparam int master_en_bit = 0;
   // Mode and wait/sense fields
   localparam int dest_lsb = 4;
   localparam int src_lsb = 2;
   localparam int pacing_bit = 1;
   localparam int mem_wait_lsb = 6;
   localparam int io_wait_lsb = 4;
   localparam int sense_ch0_bit = 3;
   localparam int sense_ch1_bit = 2;
   localparam int ch1_dir_lsb = 0;
   // Reset values
   localparam logic [7:0] mode_reset = 8'h00;
   localparam logic [7:0] wait_reset = 8'hF0;
   localparam logic [7:0] guard_read = 8'h30;
   localparam int count_width = 16;
   // Address step encodings
   typedef enum logic [1:0] {step_inc, step_dec, step_fixed, step_io} step_mode_t;
   // I/O wait table: code 00..11 gives 0,2,3,4
   localparam logic [2:0] io_wait_0 = 3'h0;
   localparam logic [2:0] io_wait_1 = 3'h2;
   localparam logic [2:0] io_wait_2 = 3'h3;
   localparam logic [2:0] io_wait_3 = 3'h4;
endpackage
